// >>> src/ptm_periodic_timer.sv
// Periodic timer: 10-bit counter, compare A and P, output pin, capture
// Assumes a one-cycle register port and pins synchronous to clk_in
//
// What this block does
// RULE_01: Mode field picks compare output, capture, PWM/single pulse, or timer.
// RULE_02: Software stops the timer before changing the mode field.
// RULE_03: Timer mode leaves the pin undriven; initial level and invert ignored.
// RULE_04: Compare mode on A match: keep, drive low, drive high or toggle.
// RULE_05: PWM mode: force inactive, force active, PWM, or single pulse.
// RULE_06: Capture on rising, falling or both edges; code 11 disables.
// RULE_07: Software changes PWM pin function only while stopped.
// RULE_08: A match requesting the initial level leaves the pin unchanged.
// RULE_09: Run bit rising returns the pin to its initial level.
// RULE_10: Initial-level bit sets start level or PWM active level.
// RULE_11: Invert bit set inverts the output pin.
// RULE_12: Capture source bit picks capture pin or external clock pin.
// RULE_13: Clear source picks A match, or P match/overflow, to clear counter.
// RULE_14: Overflow clears the counter only when compare P is zero.
// RULE_15: Clear source bit ignored in PWM, single pulse and capture.
// RULE_16: Counter is read-only as low byte and two-bit high byte.
// RULE_17: Compare A is read/write across two bytes, reset zero.
// RULE_18: Compare P is read/write across two bytes, reset zero.
// RULE_19: Compare mode, clear source 0: both A and P flags raised.
// RULE_20: Compare mode, clear source 1: only A flag, never P.
// RULE_21: Compare A zero: counter overflows at maximum without A flag.
// RULE_22: Compare mode: pin changes only on A match flag; P match never moves it.
// RULE_23: Run rising clears counter; run falling holds the count.
// RULE_24: Counter steps once per tick; comparators match on equality.
`include "ptm_map.svh"
`timescale 1ns/100ps
`default_nettype none
module ptm_periodic_timer (
	input wire logic clk_in, // 100 MHz clock
	input wire logic sys_rst_in, // Async reset, high
	input wire logic [3:0] reg_addr_in, // Register address
	input wire logic [7:0] reg_wdata_in, // Write data
	input wire logic reg_wr_in, // Write strobe
	input wire logic reg_rd_in, // Read strobe
	output logic [7:0] reg_rdata_out, // Read data, next cycle
	input wire logic capture_input_pin_in, // Capture pin
	input wire logic ext_clock_pin_in, // External clock pin
	output logic timer_output_pin_out, // Timer output level
	output logic timer_output_pin_oe_out, // Timer output enable
	output logic match_a_flag_out, // Compare A flag
	output logic match_p_flag_out // Compare P flag
);
	import ptm_pkg::*;

	logic run_ff, pin_ff, pin_oe_ff, out_lvl_ff, nxt_out_lvl;
	logic match_a_flag_ff, match_p_flag_ff, pwm_active;
	ptm_clk_t clk_sel_ff;
	ptm_mode_t op_mode_sel;
	logic [7:0] ctrl1_ff, rdata_ff, nxt_rdata;
	logic [9:0] cnt_ff, cmpa_ff, cmpp_ff, cmpp_eff;
	logic [1:0] pre_ff, pin_function_sel;
	logic output_initial_level, output_invert;
	logic capture_source_sel, clear_source_sel;
	logic ext_rise, ext_fall, cap_rise, cap_fall, src_rise, src_fall;
	logic hit_a, hit_p, tick, step, cmp_like, sp_mode;
	logic wr_c0, run_set, sp_stop, a_evt, p_evt, cap_evt, cnt_clr;

	// Control field decode
	assign op_mode_sel = ptm_mode_t'(ctrl1_ff[`PTM_C1_MODE_HI:`PTM_C1_MODE_LO]);
	assign pin_function_sel = ctrl1_ff[`PTM_C1_FN_HI:`PTM_C1_FN_LO];
	assign output_initial_level = ctrl1_ff[`PTM_C1_INIT];
	assign output_invert = ctrl1_ff[`PTM_C1_INV];
	assign capture_source_sel = ctrl1_ff[`PTM_C1_CAPSRC];
	assign clear_source_sel = ctrl1_ff[`PTM_C1_CLRSRC];
	// Compare mode and timer mode share counting behaviour
	assign cmp_like = (op_mode_sel == PTM_MODE_CMP) ||
		(op_mode_sel == PTM_MODE_TMR); // RULE_01
	assign sp_mode = (op_mode_sel == PTM_MODE_PWM) &&
		(pin_function_sel == 2'b11); // RULE_05

	// Pin edge detectors
	ptm_edge_detect u_ext_edge (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.sig_in(ext_clock_pin_in), .rise_out(ext_rise),
		.fall_out(ext_fall));
	ptm_edge_detect u_cap_edge (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.sig_in(capture_input_pin_in), .rise_out(cap_rise),
		.fall_out(cap_fall));

	// Comparators; P value zero means full 10-bit span
	assign cmpp_eff = (cmpp_ff == 10'h000) ? `PTM_CNT_MAX : cmpp_ff; // RULE_14
	ptm_match_cmp #(.W(10)) u_cmp_a (.count_in(cnt_ff), .value_in(cmpa_ff),
		.eq_out(hit_a));
	ptm_match_cmp #(.W(10)) u_cmp_p (.count_in(cnt_ff), .value_in(cmpp_eff),
		.eq_out(hit_p));

	// Counter tick selection
	always_comb begin
		unique case (clk_sel_ff)
			PTM_CLK_SYS: tick = 1'b1;
			PTM_CLK_DIV4: tick = (pre_ff == `PTM_DIV4_LAST);
			PTM_CLK_EXT_RISE: tick = ext_rise;
			PTM_CLK_EXT_FALL: tick = ext_fall;
		endcase
	end
	assign step = run_ff && tick; // RULE_24

	// Run control, software and single pulse triggers
	assign wr_c0 = reg_wr_in && (reg_addr_in == `PTM_OFS_CTRL0);
	assign run_set = !run_ff && ((wr_c0 && reg_wdata_in[`PTM_C0_RUN]) ||
		(sp_mode && ext_rise));
	assign sp_stop = sp_mode && step && hit_a;

	// Match events
	assign a_evt = step && hit_a && (op_mode_sel != PTM_MODE_CAP) &&
		!(cmp_like && (cmpa_ff == 10'h000)); // RULE_21
	assign p_evt = step && hit_p && !sp_mode &&
		!(cmp_like && clear_source_sel); // RULE_19 RULE_20

	// Capture trigger source and edge choice
	assign src_rise = capture_source_sel ? ext_rise : cap_rise; // RULE_12
	assign src_fall = capture_source_sel ? ext_fall : cap_fall; // RULE_12
	always_comb begin
		cap_evt = 1'b0;
		if (op_mode_sel == PTM_MODE_CAP && run_ff) begin
			unique case (pin_function_sel)
				2'b00: cap_evt = src_rise; // RULE_06
				2'b01: cap_evt = src_fall; // RULE_06
				2'b10: cap_evt = src_rise | src_fall; // RULE_06
				2'b11: cap_evt = 1'b0; // RULE_06
			endcase
		end
	end

	// Counter clear condition per mode
	always_comb begin
		if (cmp_like)
			cnt_clr = step && (clear_source_sel ?
				hit_a && (cmpa_ff != 10'h000) : hit_p); // RULE_13 RULE_21
		else if (sp_mode)
			cnt_clr = 1'b0;
		else
			cnt_clr = step && hit_p; // RULE_15
	end

	// Clock prescaler
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			pre_ff <= 2'h0;
		else
			pre_ff <= pre_ff + 2'h1;
	end

	// Run bit and clock select
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			run_ff <= 1'b0;
			clk_sel_ff <= PTM_CLK_SYS;
		end else begin
			if (run_set)
				run_ff <= 1'b1;
			else if (sp_stop)
				run_ff <= 1'b0;
			else if (wr_c0)
				run_ff <= reg_wdata_in[`PTM_C0_RUN]; // RULE_23
			if (wr_c0)
				clk_sel_ff <= ptm_clk_t'(
					reg_wdata_in[`PTM_C0_CLK_HI:`PTM_C0_CLK_LO]);
		end
	end

	// Mode control register
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			ctrl1_ff <= `PTM_RST_BYTE;
		else if (reg_wr_in && reg_addr_in == `PTM_OFS_CTRL1)
			ctrl1_ff <= reg_wdata_in;
	end

	// Counter; software writes never reach it
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			cnt_ff <= `PTM_RST_CNT;
		else if (run_set || cnt_clr)
			cnt_ff <= `PTM_RST_CNT; // RULE_23 RULE_13 RULE_14
		else if (step)
			cnt_ff <= cnt_ff + 10'h001; // RULE_24
	end

	// Compare A, loaded by capture or software
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			cmpa_ff <= `PTM_RST_CNT;
		else if (cap_evt)
			cmpa_ff <= cnt_ff; // RULE_06
		else if (reg_wr_in && reg_addr_in == `PTM_OFS_CMPA_LO)
			cmpa_ff[7:0] <= reg_wdata_in; // RULE_17
		else if (reg_wr_in && reg_addr_in == `PTM_OFS_CMPA_HI)
			cmpa_ff[9:8] <= reg_wdata_in[1:0]; // RULE_17
	end

	// Compare P
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			cmpp_ff <= `PTM_RST_CNT;
		else if (reg_wr_in && reg_addr_in == `PTM_OFS_CMPP_LO)
			cmpp_ff[7:0] <= reg_wdata_in; // RULE_18
		else if (reg_wr_in && reg_addr_in == `PTM_OFS_CMPP_HI)
			cmpp_ff[9:8] <= reg_wdata_in[1:0]; // RULE_18
	end

	// Match flags; a new event beats a write-one clear
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			match_a_flag_ff <= 1'b0;
			match_p_flag_ff <= 1'b0;
		end else if (reg_wr_in && reg_addr_in == `PTM_OFS_FLAGS) begin
			match_a_flag_ff <= a_evt || cap_evt ||
				(match_a_flag_ff && !reg_wdata_in[`PTM_FL_A]);
			match_p_flag_ff <= p_evt ||
				(match_p_flag_ff && !reg_wdata_in[`PTM_FL_P]);
		end else begin
			match_a_flag_ff <= match_a_flag_ff || a_evt || cap_evt;
			match_p_flag_ff <= match_p_flag_ff || p_evt; // RULE_19
		end
	end

	// PWM active state from pin function
	always_comb begin
		unique case (pin_function_sel)
			2'b00: pwm_active = 1'b0; // RULE_05
			2'b01: pwm_active = 1'b1; // RULE_05
			2'b10: pwm_active = run_ff && (cnt_ff < cmpa_ff); // RULE_05
			2'b11: pwm_active = run_ff; // RULE_05
		endcase
	end

	// Output level before inversion
	always_comb begin
		nxt_out_lvl = out_lvl_ff;
		if (op_mode_sel == PTM_MODE_PWM) begin
			nxt_out_lvl = output_initial_level ? pwm_active :
				!pwm_active; // RULE_10
		end else if (op_mode_sel == PTM_MODE_CMP) begin
			if (run_set) begin
				nxt_out_lvl = output_initial_level; // RULE_09 RULE_10
			end else if (a_evt) begin
				unique case (pin_function_sel)
					2'b00: nxt_out_lvl = out_lvl_ff; // RULE_04
					2'b01: nxt_out_lvl = output_initial_level ? 1'b0 :
						out_lvl_ff; // RULE_04 RULE_08
					2'b10: nxt_out_lvl = output_initial_level ? out_lvl_ff :
						1'b1; // RULE_04 RULE_08
					2'b11: nxt_out_lvl = !out_lvl_ff; // RULE_04
				endcase
			end
		end
	end

	// Output level, pin and enable registers
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			out_lvl_ff <= 1'b0;
			pin_ff <= 1'b0;
			pin_oe_ff <= 1'b0;
		end else begin
			out_lvl_ff <= nxt_out_lvl; // RULE_22
			pin_oe_ff <= (op_mode_sel == PTM_MODE_CMP) ||
				(op_mode_sel == PTM_MODE_PWM); // RULE_03
			if (op_mode_sel == PTM_MODE_CMP ||
				op_mode_sel == PTM_MODE_PWM)
				pin_ff <= nxt_out_lvl ^ output_invert; // RULE_11
			else
				pin_ff <= 1'b0; // RULE_03
		end
	end

	// Read data mux
	always_comb begin
		nxt_rdata = 8'h00;
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				`PTM_OFS_CTRL0: nxt_rdata = {2'b00, clk_sel_ff, run_ff, 3'b000};
				`PTM_OFS_CTRL1: nxt_rdata = ctrl1_ff;
				`PTM_OFS_CNT_LO: nxt_rdata = cnt_ff[7:0]; // RULE_16
				`PTM_OFS_CNT_HI: nxt_rdata = {6'h00, cnt_ff[9:8]}; // RULE_16
				`PTM_OFS_CMPA_LO: nxt_rdata = cmpa_ff[7:0];
				`PTM_OFS_CMPA_HI: nxt_rdata = {6'h00, cmpa_ff[9:8]};
				`PTM_OFS_CMPP_LO: nxt_rdata = cmpp_ff[7:0];
				`PTM_OFS_CMPP_HI: nxt_rdata = {6'h00, cmpp_ff[9:8]};
				`PTM_OFS_FLAGS: nxt_rdata = {6'h00, match_p_flag_ff,
					match_a_flag_ff};
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	// Read data, valid one cycle after the strobe
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			rdata_ff <= 8'h00;
		else
			rdata_ff <= nxt_rdata;
	end

	// Outputs
	assign reg_rdata_out = rdata_ff;
	assign timer_output_pin_out = pin_ff;
	assign timer_output_pin_oe_out = pin_oe_ff;
	assign match_a_flag_out = match_a_flag_ff;
	assign match_p_flag_out = match_p_flag_ff;

	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	a_run_rise_clear: assert property ( // RULE_23
		$rose(run_ff) |-> cnt_ff == 10'h000)
		else $error("counter not cleared on run start");
	a_stop_holds: assert property ( // RULE_23
		(!run_ff && !$past(run_ff)) |-> $stable(cnt_ff))
		else $error("counter moved while stopped");
	a_cmp_init_level: assert property ( // RULE_09
		($rose(run_ff) && op_mode_sel == PTM_MODE_CMP &&
		$stable(ctrl1_ff)) |-> out_lvl_ff == output_initial_level)
		else $error("pin not at initial level after run start");
	a_no_p_flag: assert property ( // RULE_20
		(cmp_like && clear_source_sel && !match_p_flag_ff) |=>
		!match_p_flag_ff)
		else $error("P flag raised with clear source A");
	a_zero_a_flag: assert property ( // RULE_21
		(op_mode_sel == PTM_MODE_CMP && cmpa_ff == 10'h000 &&
		!match_a_flag_ff) |=> !match_a_flag_ff)
		else $error("A flag raised with compare A zero");
	a_pin_a_only: assert property ( // RULE_22
		(op_mode_sel == PTM_MODE_CMP && $stable(ctrl1_ff) && !a_evt &&
		!run_set) |=> $stable(out_lvl_ff))
		else $error("pin moved without A match");
	a_ovf_wrap: assert property ( // RULE_14
		(cmp_like && !clear_source_sel && cmpp_ff == 10'h000 && step &&
		cnt_ff == `PTM_CNT_MAX && !run_set) |=> cnt_ff == 10'h000)
		else $error("no overflow clear");
	a_count_step: assert property ( // RULE_24
		(step && !cnt_clr && !run_set) |=>
		cnt_ff == $past(cnt_ff) + 10'h001)
		else $error("counter did not step on tick");
	a_capture_load: assert property ( // RULE_06
		cap_evt |=> cmpa_ff == $past(cnt_ff) && match_a_flag_ff)
		else $error("capture did not latch counter");
	a_cnt_hi_read: assert property ( // RULE_16
		(reg_rd_in && reg_addr_in == `PTM_OFS_CNT_HI) |=>
		reg_rdata_out[7:2] == 6'h00 && reg_rdata_out[1:0] ==
		$past(cnt_ff[9:8]))
		else $error("counter high byte read wrong");
	a_timer_pin_off: assert property ( // RULE_03
		(op_mode_sel == PTM_MODE_TMR) |=> !timer_output_pin_oe_out)
		else $error("pin driven in timer mode");

	c_cmp_toggle: cover property (
		op_mode_sel == PTM_MODE_CMP && a_evt && pin_function_sel == 2'b11);
	c_capture: cover property (cap_evt);
	c_sp_stop: cover property (sp_stop);
	c_p_clear: cover property (p_evt && cnt_clr);

endmodule
`default_nettype wire

// >>> inc/ptm_map.svh
// Register offsets, field positions, reset values and timing counts
// Assumes an 8-bit register port with a 4-bit byte address
`ifndef PTM_MAP_SVH
`define PTM_MAP_SVH

// Register offsets
`define PTM_OFS_CTRL0 4'h0
`define PTM_OFS_CTRL1 4'h1
`define PTM_OFS_CNT_LO 4'h2
`define PTM_OFS_CNT_HI 4'h3
`define PTM_OFS_CMPA_LO 4'h4
`define PTM_OFS_CMPA_HI 4'h5
`define PTM_OFS_CMPP_LO 4'h6
`define PTM_OFS_CMPP_HI 4'h7
`define PTM_OFS_FLAGS 4'h8

// Control 0 fields
`define PTM_C0_RUN 3
`define PTM_C0_CLK_HI 5
`define PTM_C0_CLK_LO 4

// Control 1 fields
`define PTM_C1_MODE_HI 7
`define PTM_C1_MODE_LO 6
`define PTM_C1_FN_HI 5
`define PTM_C1_FN_LO 4
`define PTM_C1_INIT 3
`define PTM_C1_INV 2
`define PTM_C1_CAPSRC 1
`define PTM_C1_CLRSRC 0

// Flag register fields
`define PTM_FL_A 0
`define PTM_FL_P 1

// Reset values and limits
`define PTM_RST_BYTE 8'h00
`define PTM_RST_CNT 10'h000
`define PTM_CNT_MAX 10'h3ff
`define PTM_DIV4_LAST 2'h3

`endif

// >>> inc/ptm_pkg.sv
// Types shared by the periodic timer files
// Assumes ptm_map.svh carries the numeric constants
package ptm_pkg;

	// Operating mode field codes
	typedef enum logic [1:0] {
		PTM_MODE_CMP = 2'b00,
		PTM_MODE_CAP = 2'b01,
		PTM_MODE_PWM = 2'b10,
		PTM_MODE_TMR = 2'b11
	} ptm_mode_t;

	// Counter clock source codes
	typedef enum logic [1:0] {
		PTM_CLK_SYS = 2'b00,
		PTM_CLK_DIV4 = 2'b01,
		PTM_CLK_EXT_RISE = 2'b10,
		PTM_CLK_EXT_FALL = 2'b11
	} ptm_clk_t;

endpackage

// >>> src/ptm_match_cmp.sv
// Equality comparator between the counter and one compare value
// Assumes both operands are stable register outputs
`timescale 1ns/100ps
`default_nettype none
module ptm_match_cmp #(
	parameter int W = 10
) (
	input wire logic [W-1:0] count_in, // Counter value
	input wire logic [W-1:0] value_in, // Compare value
	output logic eq_out // High while equal
);

	// Plain equality
	assign eq_out = (count_in == value_in);

endmodule
`default_nettype wire

// >>> src/ptm_edge_detect.sv
// Rising and falling edge detector for a pin level
// Assumes the pin is already synchronous to clk_in
`timescale 1ns/100ps
`default_nettype none
module ptm_edge_detect (
	input wire logic clk_in, // System clock
	input wire logic sys_rst_in, // Async reset, high
	input wire logic sig_in, // Pin level
	output logic rise_out, // Rising edge pulse
	output logic fall_out // Falling edge pulse
);

	logic prev_ff;

	// Previous level
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			prev_ff <= 1'b0;
		else
			prev_ff <= sig_in;
	end

	// Edge pulses
	assign rise_out = sig_in & ~prev_ff;
	assign fall_out = ~sig_in & prev_ff;

endmodule
`default_nettype wire

// >>> testbench/ptm_periodic_timer_tb.sv
// Self-checking bench for the periodic timer: registers, compare, PWM, capture
// Assumes the register map header and a 100 MHz clk_in
`include "ptm_map.svh"
`timescale 1ns/100ps
`default_nettype none
module ptm_periodic_timer_tb;
	import ptm_pkg::*;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic cap = 1'b0;
	logic ext = 1'b0;
	logic [7:0] rdata;
	logic pin;
	logic oe;
	logic fa;
	logic fp;
	logic [7:0] rv;
	logic [7:0] hv;
	integer seed = 32'h93f4;
	int fails = 0;
	int n_compared = 0;
	int cycles = 0;
	int k;
	int m;
	int n;
	int ta[4] = '{20, 3, 3, 0};
	int tp[4] = '{6, 6, 2, 0};
	int tc[4] = '{8'h30, 8'h30, 8'h31, 8'h30};
	int tw[4] = '{40, 40, 40, 1100};
	int tf[4] = '{2, 3, 1, 2};
	int tb[4] = '{0, 0, 2, 78}; // Count left after the stop

	ptm_periodic_timer i_ptm_periodic_timer (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.reg_addr_in(addr),
		.reg_wdata_in(wdata),
		.reg_wr_in(wr),
		.reg_rd_in(rd),
		.reg_rdata_out(rdata),
		.capture_input_pin_in(cap),
		.ext_clock_pin_in(ext),
		.timer_output_pin_out(pin),
		.timer_output_pin_oe_out(oe),
		.match_a_flag_out(fa),
		.match_p_flag_out(fp)
	);

	// Free-running 100 MHz clock
	always #5 clk_in = ~clk_in;

	// Hang guard
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 30000) begin
			fails++;
			end_of_test();
		end
	end

	task automatic check(input string what, input logic [7:0] seen,
			input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge clk_in);
		#1;
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
		#1;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	// Load compares and mode, clear flags, then start the counter
	task automatic setup(input logic [9:0] a, input logic [9:0] p,
			input logic [7:0] c1);
		wr_reg(`PTM_OFS_CMPA_LO, a[7:0]);
		wr_reg(`PTM_OFS_CMPA_HI, {6'h00, a[9:8]});
		wr_reg(`PTM_OFS_CMPP_LO, p[7:0]);
		wr_reg(`PTM_OFS_CMPP_HI, {6'h00, p[9:8]});
		wr_reg(`PTM_OFS_CTRL1, c1);
		wr_reg(`PTM_OFS_FLAGS, 8'h03);
		wr_reg(`PTM_OFS_CTRL0, 8'h08);
	endtask

	task automatic pin_set(input logic src, input logic v);
		@(posedge clk_in);
		if (src) ext <= v;
		else cap <= v;
		tick(6);
	endtask

	// Pin level after one A match: {fn, init, invert}
	function automatic logic cmp_level(input logic [3:0] c);
		logic lv;
		case (c[3:2])
			2'b00: lv = c[1];
			2'b01: lv = 1'b0;
			2'b10: lv = 1'b1;
			default: lv = ~c[1];
		endcase
		return lv ^ c[0];
	endfunction

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		for (k = 0; k < 8; k++) begin
			rd_reg(k[3:0], rv);
			check("reset value", rv, 8'h00);
		end
		// Compare bytes read back; flags and the unmapped place read zero, counter ignores writes
		for (k = 4; k < 10; k++) begin
			m = $random(seed);
			wr_reg(k[3:0], m[7:0]);
			rd_reg(k[3:0], rv);
			check("rw byte", rv, k > 7 ? 8'h00 : k[0] ? {6'h00, m[1:0]} : m[7:0]);
		end
		wr_reg(`PTM_OFS_CNT_LO, 8'hff);
		rd_reg(`PTM_OFS_CNT_LO, rv);
		check("count read only", rv, 8'h00);
		// Run, stop and hold the count, with wrap at the top value
		for (k = 0; k < 4; k++) begin
			n = k == 0 ? 0 : k == 1 ? 1023 : ($random(seed) & 32'h3ff);
			setup(10'h000, 10'h000, 8'hc0);
			tick(n);
			wr_reg(`PTM_OFS_CTRL0, 8'h00);
			m = (n + 2) % 1024;
			rd_reg(`PTM_OFS_CNT_LO, rv);
			check("count low", rv, m[7:0]);
			rd_reg(`PTM_OFS_CNT_HI, rv);
			check("count high", rv, {6'h00, m[9:8]});
			check("timer oe", {7'h00, oe}, 8'h00);
		end
		// Every pin function with both initial levels and inversions
		for (k = 0; k < 16; k++) begin
			setup(10'h008, 10'h000, {2'b00, k[3:0], 2'b00});
			tick(2);
			check("pin start", {7'h00, pin}, {7'h00, k[1] ^ k[0]});
			tick(12);
			check("pin match", {7'h00, pin}, {7'h00, cmp_level(k[3:0])});
			check("cmp oe", {7'h00, oe}, 8'h01);
			check("cmp flags", {6'h00, fp, fa}, 8'h01);
			wr_reg(`PTM_OFS_CTRL0, 8'h00);
		end
		// Clear sources, flag sets and a zero compare A
		for (k = 0; k < 4; k++) begin
			setup(ta[k][9:0], tp[k][9:0], tc[k][7:0]);
			tick(tw[k]);
			wr_reg(`PTM_OFS_CTRL0, 8'h00);
			check("flag set", {6'h00, fp, fa}, tf[k][7:0]);
			if (k != 1) check("pin kept", {7'h00, pin}, 8'h00);
			rd_reg(`PTM_OFS_CNT_LO, rv);
			rd_reg(`PTM_OFS_CNT_HI, hv);
			m = tb[k];
			check("count lo", rv, m[7:0]);
			check("count hi", hv, {6'h00, m[9:8]});
		end
		// PWM forced levels
		for (k = 0; k < 4; k++) begin
			setup(10'h003, 10'h008, {2'b10, 1'b0, k[1], 1'b1, k[0], 2'b00});
			tick(10);
			check("pwm forced", {7'h00, pin}, {7'h00, k[1] ^ k[0]});
			wr_reg(`PTM_OFS_CTRL0, 8'h00);
		end
		// PWM duty over nine periods of P+1 counts, clear source ignored
		setup(10'h003, 10'h008, 8'ha9);
		tick(20);
		n = 0;
		for (k = 0; k < 81; k++) begin
			tick(1);
			if (pin === 1'b1) n++;
		end
		check("pwm duty", n[7:0], 8'h1b);
		wr_reg(`PTM_OFS_CTRL0, 8'h00);
		// Single pulse ends on A match; the external pin retriggers it
		setup(10'h005, 10'h000, 8'hb8);
		tick(30);
		rd_reg(`PTM_OFS_CTRL0, rv);
		check("pulse run", {7'h00, rv[`PTM_C0_RUN]}, 8'h00);
		wr_reg(`PTM_OFS_FLAGS, 8'h03);
		pin_set(1'b1, 1'b1);
		tick(30);
		check("pulse trig", {7'h00, fa}, 8'h01);
		pin_set(1'b1, 1'b0);
		// Capture edges and source selection
		for (k = 0; k < 8; k++) begin
			setup(10'h000, 10'h000, {2'b01, k[2:1], 2'b00, k[0], 1'b0});
			pin_set(~k[0], 1'b1);
			pin_set(~k[0], 1'b0);
			check("cap other", {7'h00, fa}, 8'h00);
			pin_set(k[0], 1'b1);
			check("cap rise", {7'h00, fa}, {7'h00, k[2:1] == 2'b00 || k[2:1] == 2'b10});
			wr_reg(`PTM_OFS_FLAGS, 8'h03);
			pin_set(k[0], 1'b0);
			check("cap fall", {7'h00, fa},
				{7'h00, k[2:1] == 2'b01 || k[2:1] == 2'b10});
			wr_reg(`PTM_OFS_CTRL0, 8'h00);
		end
		end_of_test();
	end
endmodule
`default_nettype wire
